// File: src/spp_map.vh
// register map, field positions and reset values for the shared pin port
`ifndef SPP_MAP_VH
`define SPP_MAP_VH
`define SPP_DIR_ADDR 12'h000
`define SPP_LAT_ADDR 12'h004
`define SPP_PIN_ADDR 12'h008
`define SPP_CCG_ADDR 12'h00C
`define SPP_TIA_ADDR 12'h010
`define SPP_ANA_ADDR 12'h014
`define SPP_DIR_RST 16'hFFFF
`define SPP_LAT_RST 16'h0000
`define SPP_GATE_RST 16'h0000
`define SPP_ANA_RST 16'h0000
`define SPP_TIA_MASK 16'hF003
`define SPP_CAP_HI 15
`define SPP_CAP_LO 8
`define SPP_CMP_HI 7
`define SPP_CMP_LO 0
`define SPP_TMR_HI 15
`define SPP_TMR_LO 12
`define SPP_I2C_BIT 1
`define SPP_ADC_BIT 0
`define SPP_HTRANS_NONSEQ 2'h2
`define SPP_HTRANS_SEQ 2'h3
`define SPP_HRESP_OKAY 1'h0
`endif

// File: src/spp_port.v
// shared pin port slice with module gate registers behind an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "spp_map.vh"
////////////////////////////////////////////////////////////////////////
// how the slice works
//
// bus side
// - single word transfers only; the low half of each word is used
// - a write is taken in its address phase and lands at the end of the
//   data phase, so a read issued right after sees the new value
// - a read inserts one wait state: the slave drops ready for one cycle
//   while it registers the read word, so hrdata comes straight from a
//   flop and still stands for the whole last data phase cycle
// - unmapped offsets read zero and ignore writes; response is okay
//
// pin side
// - every pin has a mux pair for data and enable; the peripheral wins
//   only while it is enabled and drives, otherwise the port bit drives
//   according to its direction bit and latch
// - pin levels pass two flops before anything reads them, since the
//   board can change them at any time
// - the peripheral input shows the pin only when the port bit is not
//   driving it, so the port's own output never loops into it
// - bits left out by the implemented mask never drive and read zero, except in the analog select register, which keeps them
// - pins shared only with input functions never hand the driver over
//
// gate side
// - the two gate registers are read/write flops, clear at reset; the second keeps only bits 15:12 and 1:0
// - their outputs are registered once more, so a gate change reaches
//   the gated module one cycle after the write has landed
// - enables arriving from the system are registered once as well, so
//   the pin muxes follow a gate change by the same one cycle
// - while the second converter is gated, its select bits are frozen
//   and every pin it shares reports digital
//
// limitations
// - no open-drain, pull or change detection logic lives here
// - analog pins are not forced to read low on the port; the select
//   map is handed to the pad ring, which owns the input buffer
// - the periph_en input must already hold the system's own gating
//
`timescale 1ns/10ps
`default_nettype none
module spp_port #(
  parameter WIDTH = 16,
  parameter [15:0] IMPL_MASK = 16'hFFFF,
  parameter [15:0] INPUT_ONLY_MASK = 16'h0000
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe,
  input wire [WIDTH-1:0] periph_out,
  input wire [WIDTH-1:0] periph_oe,
  input wire [WIDTH-1:0] periph_en,
  output reg [WIDTH-1:0] periph_in,
  output reg [WIDTH-1:0] adc2_pin_map,
  output reg [7:0] capture_off,
  output reg [7:0] compare_off,
  output reg [3:0] timer_off,
  output reg second_i2c_off,
  output reg second_adc_off,
  output reg [WIDTH-1:0] analog_pin_sel
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  reg [WIDTH-1:0] pin_direction_q;
  reg [WIDTH-1:0] output_latch_q;
  reg [15:0] ccg_q;
  reg [15:0] tia_q;
  reg [WIDTH-1:0] analog_pin_select_bits_q;
  reg [WIDTH-1:0] sync1_q;
  reg [WIDTH-1:0] sync2_q;
  reg [WIDTH-1:0] gated_en_q;
  reg [11:0] addr_q;
  reg wr_q;
  reg rd_q;
  wire [WIDTH-1:0] impl;
  wire [WIDTH-1:0] own_periph;
  wire [WIDTH-1:0] pin_level;
  wire addr_phase;
  wire [15:0] wdata;
  reg [31:0] rdata_d;
  // reset images cut to the port width on purpose
  localparam [15:0] DIR_RST = `SPP_DIR_RST;
  localparam [15:0] LAT_RST = `SPP_LAT_RST;
  localparam [15:0] ANA_RST = `SPP_ANA_RST;

  assign impl = IMPL_MASK[WIDTH-1:0];
  assign wdata = hwdata[15:0];
  assign addr_phase = hsel & hready & (htrans == `SPP_HTRANS_NONSEQ |
                      htrans == `SPP_HTRANS_SEQ);

  // write strobes, one per register, valid in the data phase
  wire wr_dir = wr_q & (addr_q == `SPP_DIR_ADDR);
  wire wr_lat = wr_q & ((addr_q == `SPP_LAT_ADDR) |
                (addr_q == `SPP_PIN_ADDR));
  wire wr_ccg = wr_q & (addr_q == `SPP_CCG_ADDR);
  wire wr_tia = wr_q & (addr_q == `SPP_TIA_ADDR);
  wire wr_ana = wr_q & (addr_q == `SPP_ANA_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture; a read costs one wait state so that
  // its data can come from a flop and stand for the whole data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= `SPP_HRESP_OKAY;
    end else begin
      addr_q <= haddr;
      wr_q <= addr_phase & hwrite;
      rd_q <= addr_phase & ~hwrite;
      hreadyout <= ~(addr_phase & ~hwrite);
      hresp <= `SPP_HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // direction bits; ones make inputs, so reset leaves every pin undriven
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_direction_q <= DIR_RST[WIDTH-1:0];
    end else if (wr_dir) begin
      pin_direction_q <= wdata[WIDTH-1:0] & impl;
    end
  end

  // output latch; both the latch and the pin level offsets write here
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_latch_q <= LAT_RST[WIDTH-1:0];
    end else if (wr_lat) begin
      output_latch_q <= wdata[WIDTH-1:0] & impl;
    end
  end

  // capture and compare gate bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ccg_q <= `SPP_GATE_RST;
    end else if (wr_ccg) begin
      ccg_q <= wdata;
    end
  end

  // timer, i2c and converter gate bits; the middle bits never store
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tia_q <= `SPP_GATE_RST;
    end else if (wr_tia) begin
      tia_q <= wdata & `SPP_TIA_MASK;
    end
  end

  // select bits belong to the second converter: frozen while it is off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pin_select_bits_q <= ANA_RST[WIDTH-1:0];
    end else if (wr_ana & ~tia_q[`SPP_ADC_BIT]) begin
      analog_pin_select_bits_q <= wdata[WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (addr_q)
      `SPP_DIR_ADDR: rdata_d[WIDTH-1:0] = pin_direction_q & impl;
      `SPP_LAT_ADDR: rdata_d[WIDTH-1:0] = output_latch_q & impl;
      `SPP_PIN_ADDR: rdata_d[WIDTH-1:0] = sync2_q & impl;
      `SPP_CCG_ADDR: rdata_d[15:0] = ccg_q;
      `SPP_TIA_ADDR: rdata_d[15:0] = tia_q & `SPP_TIA_MASK;
      `SPP_ANA_ADDR: rdata_d[WIDTH-1:0] = analog_pin_select_bits_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data cleared as the address phase is taken, registered one cycle later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= 32'h00000000;
    end else if (rd_q) begin
      hrdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser; the first stage feeds only the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= {WIDTH{1'b0}};
      sync2_q <= {WIDTH{1'b0}};
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture gates, registered so a change lands one cycle after the write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_off <= 8'h00;
    end else begin
      capture_off <= ccg_q[`SPP_CAP_HI:`SPP_CAP_LO];
    end
  end

  // compare gates, same one cycle lag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_off <= 8'h00;
    end else begin
      compare_off <= ccg_q[`SPP_CMP_HI:`SPP_CMP_LO];
    end
  end

  // timer gates, fifteen down to twelve
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_off <= 4'h0;
    end else begin
      timer_off <= tia_q[`SPP_TMR_HI:`SPP_TMR_LO];
    end
  end

  // second i2c gate
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_i2c_off <= 1'b0;
    end else begin
      second_i2c_off <= tia_q[`SPP_I2C_BIT];
    end
  end

  // second converter gate
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_adc_off <= 1'b0;
    end else begin
      second_adc_off <= tia_q[`SPP_ADC_BIT];
    end
  end

  // converter off forces all select bits digital (one means digital)
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pin_sel <= {WIDTH{1'b0}};
    end else begin
      analog_pin_sel <= tia_q[`SPP_ADC_BIT] ? {WIDTH{1'b1}}
                        : analog_pin_select_bits_q;
    end
  end

  // gated peripheral looks disabled; input-only pins never hand over
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gated_en_q <= {WIDTH{1'b0}};
    end else begin
      gated_en_q <= periph_en & ~INPUT_ONLY_MASK[WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin output mux pair and loop-through block
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      // peripheral owns the driver only while enabled and driving
      assign own_periph[i] = gated_en_q[i] & periph_oe[i];

      // data mux: peripheral data while it owns the pin, else the latch
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_out[i] <= 1'b0;
        end else begin
          pin_out[i] <= impl[i] & (own_periph[i] ? periph_out[i]
                        : output_latch_q[i]);
        end
      end

      // enable mux: the owner's enable, or the port's direction bit
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_oe[i] <= 1'b0;
        end else begin
          pin_oe[i] <= impl[i] & (own_periph[i] ? 1'b1
                       : ~pin_direction_q[i]);
        end
      end

      // a port-driven pin shows zero to the peripheral input
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          periph_in[i] <= 1'b0;
        end else begin
          periph_in[i] <= impl[i] & (own_periph[i] | pin_direction_q[i])
                          & sync2_q[i];
        end
      end

      // analog map for the pad ring; one means the pin is analog
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          adc2_pin_map[i] <= 1'b0;
        end else begin
          adc2_pin_map[i] <= ~analog_pin_sel[i];
        end
      end
    end
  endgenerate

  assign pin_level = sync2_q;

endmodule
`default_nettype wire

// File: verif/spp_chk.sv
// concurrent checks on the shared pin port outputs
`timescale 1ns/10ps
`default_nettype none
`include "spp_map.vh"
module spp_chk #(parameter WIDTH = 16) (
  input wire logic hclk, hresetn, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hwdata,
  input wire logic [WIDTH-1:0] pin_out, pin_oe, periph_out, periph_oe,
  input wire logic [WIDTH-1:0] periph_en, periph_in, adc2_pin_map,
  input wire logic [7:0] capture_off, compare_off,
  input wire logic [3:0] timer_off,
  input wire logic second_i2c_off, second_adc_off
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a transfer taken in an address phase
  wire logic take = hsel && hready && htrans[1];
  ////////////////////////////////////////////////////////////////////////
  own_drive_a: assert property ((periph_en[0] && periph_oe[0]) [*3] |-> pin_oe[0])
    else $error("owned pin not driven");
  own_data_a: assert property ((periph_en[0] && periph_oe[0] && $stable(periph_out[0])) [*3]
    |-> pin_out[0] == periph_out[0]) else $error("owned pin data wrong");
  no_loop_a: assert property ((pin_oe[8] && !periph_oe[8]) [*3] |-> !periph_in[8])
    else $error("port output looped into peripheral");
  cap_gate_a: assert property ($changed({capture_off, compare_off}) |->
    $past(take && hwrite && haddr == `SPP_CCG_ADDR, 3) &&
    {capture_off, compare_off} == $past(hwdata[15:0], 2)) else $error("capture gate");
  tmr_gate_a: assert property ($changed({timer_off, second_i2c_off, second_adc_off}) |->
    $past(take && hwrite && haddr == `SPP_TIA_ADDR, 3) &&
    timer_off == $past(hwdata[15:12], 2) &&
    {second_i2c_off, second_adc_off} == $past(hwdata[1:0], 2)) else $error("timer gate");
  adc_digital_a: assert property (second_adc_off [*3] |-> adc2_pin_map == '0)
    else $error("analog map while adc off");
  okay_resp_a: assert property (hresp == `SPP_HRESP_OKAY) else $error("response not okay");
  ready_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  ready_low_a: assert property (!hreadyout |-> $past(take && !hwrite))
    else $error("ready low without read");
  cover property (take && hwrite);
  cover property (periph_en[0] && periph_oe[0]);
  cover property (second_adc_off);
endmodule
`default_nettype wire

// File: verif/spp_far.sv
// pad model: resolves each pin from the port driver and the board level
`timescale 1ns/10ps
`default_nettype none
module spp_far #(parameter WIDTH = 16) (
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] ext,
  output logic [WIDTH-1:0] pin_in
);
  // a driven pin shows the driver, so the board value never fights it
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

// File: verif/test_spp_port.sv
// self-checking bench for the shared pin port
`timescale 1ns/10ps
`default_nettype none
`include "spp_map.vh"
module test_spp_port;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, second_i2c_off, second_adc_off;
  logic [15:0] pin_in, pin_out, pin_oe, ext = 16'h0, periph_out = 16'h0;
  logic [15:0] periph_oe = 16'h0, periph_en = 16'h0, periph_in, adc2_pin_map, analog_pin_sel;
  logic [7:0] capture_off, compare_off;
  logic [3:0] timer_off;
  int fails = 0, cmp_count = 0, cyc = 0;
  // bit 15 left out to exercise a missing port bit
  // bit 2 is shared only with an input function
  spp_port #(.IMPL_MASK(16'h7FFF), .INPUT_ONLY_MASK(16'h0004))
    spp_port_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .pin_in, .pin_out, .pin_oe, .periph_out, .periph_oe, .periph_en, .periph_in,
    .adc2_pin_map, .capture_off, .compare_off, .timer_off, .second_i2c_off,
    .second_adc_off, .analog_pin_sel);
  spp_far spp_far_inst (.pin_out, .pin_oe, .ext, .pin_in);
  initial begin
    forever #50 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single AHB transfer; waits on ready, the timeout ends a hang
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `SPP_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(pin_oe, 32'h0);
    rdc(`SPP_DIR_ADDR, 32'h7FFF);
    rdc(`SPP_CCG_ADDR, 32'h0);
    rdc(`SPP_TIA_ADDR, 32'h0);
  endtask
  task automatic t_port;
    bus(1'b1, `SPP_ANA_ADDR, 32'hFFFF);
    bus(1'b1, `SPP_DIR_ADDR, 32'h0);
    bus(1'b1, `SPP_LAT_ADDR, 32'hA5C3);
    rdc(`SPP_LAT_ADDR, 32'h25C3);
    chk(pin_oe, 32'h7FFF);
    rdc(`SPP_PIN_ADDR, 32'h25C3);
    bus(1'b1, `SPP_PIN_ADDR, 32'h1234);
    rdc(`SPP_LAT_ADDR, 32'h1234);
    ext <= 16'hBC0F;
    bus(1'b1, `SPP_DIR_ADDR, 32'hFFFF);
    repeat (3) @(posedge hclk);
    rdc(`SPP_PIN_ADDR, 32'h3C0F);
    chk(pin_oe, 32'h0);
  endtask
  // low byte owned by a driving peripheral except input-only bit 2, high byte enabled but idle
  task automatic t_share;
    periph_en <= 16'hFFFF;
    periph_oe <= 16'h00FF;
    periph_out <= 16'h0055;
    bus(1'b1, `SPP_DIR_ADDR, 32'h0);
    bus(1'b1, `SPP_LAT_ADDR, 32'hFF00);
    repeat (3) @(posedge hclk);
    chk(pin_oe, 32'h7FFF);
    chk(pin_out & 16'h7FFF, 32'h7F51);
    chk(periph_in & 16'hFF04, 32'h0);
    rdc(`SPP_PIN_ADDR, 32'h7F51);
  endtask
  task automatic t_gate;
    bus(1'b1, `SPP_CCG_ADDR, 32'h5AA5);
    rdc(`SPP_CCG_ADDR, 32'h5AA5);
    chk({capture_off, compare_off}, 32'h5AA5);
    bus(1'b1, `SPP_TIA_ADDR, 32'hFFFF);
    rdc(`SPP_TIA_ADDR, 32'hF003);
    chk({timer_off, second_i2c_off, second_adc_off}, 32'h3F);
    bus(1'b1, `SPP_ANA_ADDR, 32'h0);
    repeat (3) @(posedge hclk);
    chk(analog_pin_sel, 32'hFFFF);
    chk(adc2_pin_map, 32'h0);
    rdc(12'h020, 32'h0);
    rdc(`SPP_ANA_ADDR, 32'hFFFF);
    bus(1'b1, `SPP_TIA_ADDR, 32'h0);
    bus(1'b1, `SPP_CCG_ADDR, 32'h0);
    rdc(`SPP_CCG_ADDR, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard: the whole run needs about a hundred cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_port;
    t_share;
    t_gate;
    give_verdict;
  end
endmodule
bind spp_port spp_chk #(.WIDTH(WIDTH)) spp_chk_inst (.hclk, .hresetn, .hsel,
  .hready, .hwrite, .hreadyout, .hresp, .haddr, .htrans, .hwdata, .pin_out, .pin_oe,
  .periph_out, .periph_oe, .periph_en, .periph_in, .adc2_pin_map, .capture_off,
  .compare_off, .timer_off, .second_i2c_off, .second_adc_off);
`default_nettype wire
